// File: verif/ovrtm_link_sink.sv
/* link receiver model: pops words, keeps the last one and a count.
   assumes: mode 0 stalls, 1 always ready, 2 ready every other cycle. */
`timescale 1ns/1ns
module ovrtm_link_sink
	import ovrtm_pkg::*;
(
	input  wire logic	i_clk,
	input  wire logic	i_rst,
	input  wire logic [1:0]	i_mode,
	input  wire logic	i_valid,
	input  wire logic [4*OVRTM_LINK_W-1:0]	i_word,
	output logic	o_ready,
	output logic [4*OVRTM_LINK_W-1:0]	o_word,
	output int	o_count
);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ready <= 1'h0;
			o_count <= 0;
		end else begin
			o_ready <= i_mode == 2'h1 || (i_mode == 2'h2 && !o_ready);
			if (i_valid && o_ready) begin
				o_count <= o_count + 1;
				o_word <= i_word;
			end
		end
	end
endmodule

// File: verif/ovrtm_top_properties.sv
/* port checker for ovrtm_top.
   assumes: bound onto ovrtm_top, single clock, sync reset. */
`timescale 1ns/1ns
module ovrtm_top_properties
	import ovrtm_pkg::*;
#(parameter int NUM_CH = OVRTM_NUM_CH) (
	input wire logic	i_clk,
	input wire logic	i_rst,
	input wire logic [NUM_CH-1:0][OVRTM_SAMPLE_W-1:0]	i_sample,
	input wire logic	i_sample_valid,
	input wire logic	i_trigger_mark_input,
	input wire ovrtm_cfg_type	i_cfg,
	input wire logic	i_link_ready,
	input wire logic [NUM_CH-1:0]	o_flag_pin,
	input wire logic	o_trigger_repeat_output,
	input wire logic [NUM_CH*OVRTM_LINK_W-1:0]	o_link_word,
	input wire logic	o_link_valid,
	input wire logic	o_sample_ready
);
	logic [7:0]	mag0;
	logic	ev;
	logic	rep;
	// ----
	// events on channel A only: keeps the checker small
	// ----
	always_comb mag0 = i_sample[0] == 9'h100 ? 8'hFF :
		i_sample[0][8] ? 8'(-i_sample[0]) : i_sample[0][7:0];
	assign ev = i_sample_valid && i_cfg.detect_enable && mag0 >= i_cfg.threshold;
	assign rep = i_cfg.repeat_enable && i_cfg.receiver_enable &&
		i_cfg.repeat_source_select == OVRTM_TRIG_MODE_MARK;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_flag_clear: assert property (!i_cfg.detect_enable |=> o_flag_pin == '0)
		else $error("flag while disabled");
	chk_flag_set: assert property (ev |=> o_flag_pin[0])
		else $error("flag missed");
	chk_flag_stay: assert property (ev |=> (o_flag_pin[0] || !i_cfg.detect_enable)[*8])
		else $error("flag short");
	chk_flag_end: assert property (ev ##1 (!ev && i_cfg.hold_select == 3'h0
		&& i_cfg.detect_enable)[*8] |=> !o_flag_pin[0]) else $error("flag long");
	chk_rep_follow: assert property (rep[*4] |->
		o_trigger_repeat_output == $past(i_trigger_mark_input, 3)) else $error("repeat");
	chk_rep_off: assert property (!rep |=> !o_trigger_repeat_output)
		else $error("repeat while off");
	chk_link_lat: assert property (i_sample_valid && !o_link_valid |-> ##2 o_link_valid)
		else $error("word late");
	chk_word_hold: assert property (o_link_valid && !i_link_ready |=>
		o_link_valid && $stable(o_link_word)) else $error("word dropped");
endmodule
bind ovrtm_top ovrtm_top_properties #(.NUM_CH(NUM_CH)) ovrtm_top_properties_inst (
	.i_clk(i_clk), .i_rst(i_rst), .i_sample(i_sample), .i_sample_valid(i_sample_valid),
	.i_trigger_mark_input(i_trigger_mark_input), .i_cfg(i_cfg), .i_link_ready(i_link_ready),
	.o_flag_pin(o_flag_pin), .o_trigger_repeat_output(o_trigger_repeat_output),
	.o_link_word(o_link_word), .o_link_valid(o_link_valid), .o_sample_ready(o_sample_ready));

// File: verif/tb_ovrtm_top.sv
/* testbench for ovrtm_top: flags, hold, trigger repeat, link words.
   assumes: link sink model and the bound checker. */
`timescale 1ns/1ns
module tb_ovrtm_top;
	import ovrtm_pkg::*;
	logic	clk, rst, vld, trig, rep, lvalid, lready, sready;
	logic [3:0][8:0]	smp, lw;
	logic [3:0]	flag;
	logic [47:0]	lword, got;
	logic [1:0]	smode;
	ovrtm_cfg_type	cfg;
	int	cnt, errors, n_checks, i, j, k, c;
	logic [8:0]	ts [9] = '{9'h0FF, 9'h0FE, 9'h000, 9'h102, 9'h100, 9'h0E4, 9'h0E3, 9'h11C, 9'h11D};
	logic [8:0]	te = 9'h0BB;
	ovrtm_top #(.NUM_CH(4), .FIFO_DEPTH(16)) ovrtm_top_inst (.i_clk(clk), .i_rst(rst),
		.i_sample(smp), .i_sample_valid(vld), .i_trigger_mark_input(trig), .i_cfg(cfg),
		.i_link_ready(lready), .o_flag_pin(flag), .o_trigger_repeat_output(rep),
		.o_link_word(lword), .o_link_valid(lvalid), .o_sample_ready(sready));
	ovrtm_link_sink ovrtm_link_sink_inst (.i_clk(clk), .i_rst(rst), .i_mode(smode),
		.i_valid(lvalid), .i_word(lword), .o_ready(lready), .o_word(got), .o_count(cnt));
	// ----
	// tasks
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [3:0][8:0] v);
		@(posedge clk);
		smp <= v;
		vld <= 1'h1;
		@(posedge clk);
		vld <= 1'h0;
	endtask
	task report_and_stop;
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		#600000;
		errors++;
		report_and_stop;
	end
	// ----
	// sequence
	// ----
	initial begin
		rst = 1'h1; vld = 1'h0; trig = 1'h0; smp = '0; smode = 2'h1;
		cfg = '{8'hE4, 1'h1, 3'h0, 1'h1, 2'h3, 1'h1, 1'h1, 2'h0};
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		#1 check(flag, 0);
		for (i = 0; i < 9; i++) begin
			lw = '0;
			lw[i%4] = ts[i];
			send(lw);
			#1 check(flag[i%4], te[i]);
			repeat (12) @(posedge clk);
		end
		cfg.detect_enable <= 1'h0;
		send({4{9'h100}});
		#1 check(flag, 0);
		@(posedge clk) cfg.detect_enable <= 1'h1;
		for (i = 0; i < 8; i++) begin
			@(posedge clk) cfg.hold_select <= i[2:0];
			send({4{9'h100}});
			j = 0;
			#1;
			while (flag[0] === 1'h1 && j < 2000) begin
				j++;
				@(posedge clk);
				#1;
			end
			check(j[15:0], 16'(1 << (3 + i)));
		end
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			cfg.repeat_source_select <= i[1:0];
			trig <= 1'h1;
			repeat (4) @(posedge clk);
			#1 check(rep, i == 3);
			@(posedge clk) trig <= 1'h0;
			repeat (4) @(posedge clk);
		end
		lw = {9'h1A3, 9'h0C5, 9'h15A, 9'h03B};
		// mark only with insertion on: iterations 0 low, 1 high, 2 high but off
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			trig <= i != 0;
			cfg.insert_enable <= i != 2;
			repeat (3) @(posedge clk);
			k = cnt;
			send(lw);
			for (j = 0; j < 50 && cnt == k; j++) @(posedge clk);
			#1;
			for (c = 0; c < 4; c++) begin
				check(got[c*12+3+:9], lw[c]);
				check(got[c*12], i == 1);
			end
		end
		@(posedge clk) smode <= 2'h0;
		repeat (3) @(posedge clk);
		k = cnt;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			smp <= {4{i[8:0]}};
			vld <= 1'h1;
		end
		@(posedge clk) vld <= 1'h0;
		repeat (2) @(posedge clk);
		#1 check(sready, 0);
		@(posedge clk) smode <= 2'h2;
		for (j = 0; j < 400 && lvalid !== 1'h0; j++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1 k = cnt - k;
		check(k >= 16 && k <= 20, 1);
		check(got[11:3], 16'(k - 1));
		check(sready, 1);
		report_and_stop;
	end
endmodule

// File: verilog/ovrtm_fifo.sv
/*
 * ovrtm_fifo: synchronous valid/ready FIFO, width and depth parameters.
 * assumes: single clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
module ovrtm_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic      [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} ovrtm_fifo_state_type;

	ovrtm_fifo_state_type st_r;
	ovrtm_fifo_state_type st_nxt;
	logic [WIDTH-1:0]     mem_r [DEPTH];
	logic                 push;
	logic                 pop;

	assign o_ready = (st_r.cnt != (AW+1)'(DEPTH));
	assign o_valid = (st_r.cnt != '0);
	assign o_data  = mem_r[st_r.rd];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.wr = (st_r.wr == AW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd = (st_r.rd == AW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
		if (push) begin
			mem_r[st_r.wr] <= i_data;
		end
	end
endmodule

// File: verilog/ovrtm_pkg.sv
/*
 * ovrtm_pkg: constants and carrier types for the over-range flag and
 * trigger-mark block.
 * assumes: one sampling clock domain, nothing else.
 */
package ovrtm_pkg;
	localparam int          OVRTM_SAMPLE_W     = 9;
	localparam int          OVRTM_MAG_W        = 8;
	localparam int          OVRTM_LINK_W       = 12;
	localparam int          OVRTM_NUM_CH       = 4;
	localparam int          OVRTM_HOLD_W       = 11;
	localparam int          OVRTM_HOLD_BASE_LOG = 3;
	localparam logic [1:0]  OVRTM_TRIG_MODE_MARK = 2'h3;
	localparam logic [1:0]  OVRTM_LINK_MODE_0  = 2'h0;
	localparam logic [7:0]  OVRTM_MAG_SAT      = 8'hFF;
	localparam logic [10:0] OVRTM_HOLD_RST     = 11'h000;
	localparam int          OVRTM_FIFO_DEPTH   = 16;

	// one channel's sample with its marked trigger bit
	typedef struct packed {
		logic [OVRTM_SAMPLE_W-1:0] sample;
		logic                      mark;
	} ovrtm_word_type;

	typedef struct packed {
		logic [7:0] threshold;
		logic       detect_enable;
		logic [2:0] hold_select;
		logic       repeat_enable;
		logic [1:0] repeat_source_select;
		logic       receiver_enable;
		logic       insert_enable;
		logic [1:0] link_mode_select;
	} ovrtm_cfg_type;
endpackage

// File: verilog/ovrtm_top.sv
/*
 * ovrtm_top: per-channel over-range flags with programmable hold, and
 * trigger mark retiming, repeat and link-word insertion.
 * assumes: everything on the sampling clock i_clk; the trigger mark pin is
 * asynchronous; link words drain through a FIFO the receiver may stall.
 */
// Operation
// - compare low 8 magnitude bits to threshold
// - magnitude saturates, most negative gives 255
// - detection works only while enabled
// - flag high when magnitude reaches threshold
// - one flag pin per channel
// - hold select picks 8 to 1024 cycles
// - retime trigger, repeat it in mode 3
// - insertion replaces word LSB with trigger
// - link mode 0: trigger bit 0, sample above
// - trigger path latency is sample latency plus two sync cycles
// - trigger input may be asynchronous
// - samples are signed two's complement
`timescale 1ns/1ns
module ovrtm_top
	import ovrtm_pkg::*;
#(
	parameter int NUM_CH     = OVRTM_NUM_CH,
	parameter int FIFO_DEPTH = OVRTM_FIFO_DEPTH
) (
	input  wire logic                                 i_clk,
	input  wire logic                                 i_rst,
	input  wire logic [NUM_CH-1:0][OVRTM_SAMPLE_W-1:0] i_sample,
	input  wire logic                                 i_sample_valid,
	input  wire logic                                 i_trigger_mark_input,
	input  wire ovrtm_cfg_type                        i_cfg,
	input  wire logic                                 i_link_ready,
	output logic      [NUM_CH-1:0]                    o_flag_pin,
	output logic                                      o_trigger_repeat_output,
	output logic      [NUM_CH*OVRTM_LINK_W-1:0]       o_link_word,
	output logic                                      o_link_valid,
	output logic                                      o_sample_ready
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// two's complement in, saturated 8-bit magnitude of the low bits out
	function automatic logic [OVRTM_MAG_W-1:0] ovrtm_mag(
		input logic [OVRTM_SAMPLE_W-1:0] s
	);
		logic [OVRTM_SAMPLE_W-1:0] a;
		a = s[OVRTM_SAMPLE_W-1] ? (~s + 1'b1) : s;
		if (a[OVRTM_SAMPLE_W-1]) begin
			ovrtm_mag = OVRTM_MAG_SAT;
		end else begin
			ovrtm_mag = a[OVRTM_MAG_W-1:0];
		end
	endfunction

	function automatic logic [OVRTM_HOLD_W-1:0] ovrtm_hold_len(input logic [2:0] sel);
		ovrtm_hold_len = OVRTM_HOLD_W'(1) << (OVRTM_HOLD_BASE_LOG + int'(sel));
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                                      trig_meta;
		logic                                      trig_sync;
		logic [NUM_CH-1:0][OVRTM_HOLD_W-1:0]       hold;
		logic [NUM_CH-1:0]                         flag;
		logic                                      repeat_out;
		logic [NUM_CH-1:0][OVRTM_SAMPLE_W-1:0]     smp;
		logic                                      smp_mark;
		logic                                      smp_valid;
	} ovrtm_state_type;

	ovrtm_state_type                  st_r;
	ovrtm_state_type                  st_nxt;
	logic [NUM_CH*OVRTM_LINK_W-1:0]   word_in;
	logic                             fifo_ready;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// async trigger pin through two flops before use
		st_nxt.trig_meta = i_trigger_mark_input;
		st_nxt.trig_sync = st_r.trig_meta;
		st_nxt.repeat_out = i_cfg.receiver_enable && i_cfg.repeat_enable
			&& (i_cfg.repeat_source_select == OVRTM_TRIG_MODE_MARK) && st_r.trig_sync;
		for (int c = 0; c < NUM_CH; c++) begin
			if (!i_cfg.detect_enable) begin
				st_nxt.hold[c] = OVRTM_HOLD_RST;
				st_nxt.flag[c] = 1'b0;
			end else if (i_sample_valid
				&& (ovrtm_mag(i_sample[c]) >= i_cfg.threshold)) begin
				// restart hold on every event so it runs from the last one
				st_nxt.hold[c] = ovrtm_hold_len(i_cfg.hold_select) - 1'b1;
				st_nxt.flag[c] = 1'b1;
			end else if (st_r.hold[c] != '0) begin
				st_nxt.hold[c] = st_r.hold[c] - 1'b1;
				st_nxt.flag[c] = 1'b1;
			end else begin
				st_nxt.flag[c] = 1'b0;
			end
		end
		// sample and mark registered together so both see one stage
		// stage keeps its word until the FIFO takes it; samples arriving while it waits are dropped
		if (!st_r.smp_valid || fifo_ready) begin
			st_nxt.smp_valid = i_sample_valid;
			if (i_sample_valid) begin
				st_nxt.smp      = i_sample;
				st_nxt.smp_mark = i_cfg.receiver_enable && st_r.trig_sync;
			end
		end
	end

	// ---------------------------------------------------------------
	// link word assembly
	// ---------------------------------------------------------------
	// other link modes keep the same left-justified layout; only mode 0 is defined
	always_comb begin
		word_in = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			word_in[c*OVRTM_LINK_W +: OVRTM_LINK_W] =
				{st_r.smp[c], {(OVRTM_LINK_W-OVRTM_SAMPLE_W){1'b0}}};
			if (i_cfg.insert_enable) begin
				word_in[c*OVRTM_LINK_W] = st_r.smp_mark;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_flag_pin              = st_r.flag;
	assign o_trigger_repeat_output = st_r.repeat_out;

	// ---------------------------------------------------------------
	// output buffer
	// ---------------------------------------------------------------
	// receiver stall fills the FIFO, then o_sample_ready drops for the source
	ovrtm_fifo #(
		.WIDTH (NUM_CH*OVRTM_LINK_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (st_r.smp_valid),
		.o_ready (fifo_ready),
		.i_data  (word_in),
		.o_valid (o_link_valid),
		.i_ready (i_link_ready),
		.o_data  (o_link_word)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sample_ready <= 1'b0;
		end else begin
			o_sample_ready <= fifo_ready;
		end
	end
endmodule
